// *** hw/scpc_map.vh ***
// Purpose: Constants for the serdes pin and configuration control block
// Assumes: 200 MHz system clock
// Notes:   Codes of the two-bit partner/mode input and level encodings
`ifndef SCPC_MAP_VH
`define SCPC_MAP_VH
`define SCPC_MODE_MATE_NOFILT 2'h0
`define SCPC_MODE_MATE_FILT   2'h1
`define SCPC_MODE_OLD_A       2'h2
`define SCPC_MODE_OLD_B       2'h3
`define SCPC_SWING_HIGH       1'h1
`define SCPC_SPREAD_LOW_BAND  1'h1
`define SCPC_FIFO_DEPTH       8
`define SCPC_LANE_W           7
`define SCPC_LANES            4
`define SCPC_ADDR_W           3
`endif

// *** hw/scpc_fifo.v ***
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-low reset
// Notes:   Module body sits with the top level, which holds all design logic
`default_nettype none
`default_nettype wire

// *** hw/scpc_top.v ***
// Purpose: Pin-strapped control and status of a serializer/deserializer pair
// Assumes: One 200 MHz clock; link clock is sampled as a plain input
// Notes:   Analog effects appear as select outputs for the analog macros
`timescale 1ns/1ps
`default_nettype none
`include "scpc_map.vh"
module scpc_top #(
  parameter LANE_W = `SCPC_LANE_W,
  parameter LANES  = `SCPC_LANES,
  parameter DEPTH  = `SCPC_FIFO_DEPTH
) (
  input  wire                    sys_clk_i,
  input  wire                    resetn_i,
  input  wire                    power_down_n_i,
  input  wire [1:0]              mode_sel_i,
  input  wire                    lane_bit_map_select_i,
  input  wire                    output_swing_select_i,
  input  wire                    tx_emphasis_control_i,
  input  wire                    self_test_enable_i,
  input  wire                    rx_equalizer_strap_i,
  input  wire                    spread_low_band_mode_i,
  input  wire [2:0]              spread_range_select_i,
  input  wire                    output_enable_in_i,
  input  wire                    output_sleep_state_select_i,
  input  wire [`SCPC_ADDR_W-1:0] bus_address_strap_i,
  input  wire                    reserved_input_i,
  input  wire                    pll_locked_i,
  input  wire                    test_error_i,
  input  wire                    reg_write_i,
  input  wire [1:0]              reg_mode_i,
  input  wire                    reg_map_i,
  input  wire                    reg_swing_i,
  input  wire                    reg_emphasis_i,
  input  wire                    scl_i,
  input  wire                    sda_i,
  output reg                     sda_o,
  output reg                     sda_oe_o,
  input  wire                    parallel_clock_in_i,
  input  wire [LANES*LANE_W-1:0] parallel_data_in_i,
  output reg  [LANES*LANE_W-1:0] parallel_data_out_o,
  output reg                     parallel_out_valid_o,
  output reg                     parallel_out_enable_o,
  output reg                     in_ready_o,
  output reg                     pll_run_o,
  output reg                     serial_pos_o,
  output reg                     serial_neg_o,
  output reg                     filter_on_o,
  output reg                     legacy_mode_o,
  output reg  [1:0]              partner_o,
  output reg                     swing_high_o,
  output reg                     emphasis_on_o,
  output reg                     eq_high_o,
  output reg                     spread_low_band_o,
  output reg  [2:0]              spread_range_o,
  output reg                     test_mode_o,
  output reg                     pass_o,
  output reg                     lock_o,
  output reg  [`SCPC_ADDR_W-1:0] bus_address_o
);
  localparam W   = LANES*LANE_W;
  localparam FAW = $clog2(DEPTH);
  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers on the control, strap, status, link clock and scl pin inputs
  localparam NS = 18;
  wire [NS-1:0] raw = {power_down_n_i, lane_bit_map_select_i, output_swing_select_i,
                       tx_emphasis_control_i, self_test_enable_i, rx_equalizer_strap_i,
                       spread_low_band_mode_i, output_enable_in_i,
                       output_sleep_state_select_i, pll_locked_i, test_error_i,
                       parallel_clock_in_i, mode_sel_i, spread_range_select_i, scl_i};
  reg  [NS-1:0] s1_q;
  reg  [NS-1:0] s2_q;
  always @(posedge sys_clk_i) begin
    s1_q <= raw;
    s2_q <= s1_q;
  end
  // Address strap is a pin as well, so it gets its own two stages
  reg  [`SCPC_ADDR_W-1:0] addr_s1_q;
  reg  [`SCPC_ADDR_W-1:0] addr_s2_q;
  always @(posedge sys_clk_i) begin
    addr_s1_q <= bus_address_strap_i;
    addr_s2_q <= addr_s1_q;
  end
  wire       pdn     = s2_q[17];
  wire       map_pin = s2_q[16];
  wire       swg_pin = s2_q[15];
  wire       emp_pin = s2_q[14];
  wire       bist    = s2_q[13];
  wire       eq_pin  = s2_q[12];
  wire       lfm     = s2_q[11];
  wire       output_enable_in     = s2_q[10];
  wire       oss     = s2_q[9];
  wire       locked  = s2_q[8];
  wire       err     = s2_q[7];
  wire       lclk    = s2_q[6];
  wire [1:0] cfg_pin = s2_q[5:4];
  wire [2:0] ssc     = s2_q[3:1];
  // Reset covers both the reset port and the power-down pin
  wire       rst     = !resetn_i || !pdn;
  ////////////////////////////////////////////////////////////////////////////
  // Control registers, pin value until software writes them; mode takes only the filter bit and emphasis is ORed with the pin
  reg       sw_q;
  reg [1:0] rmode_q;
  reg       rmap_q;
  reg       rswg_q;
  reg       remp_q;
  always @(posedge sys_clk_i) begin
    if (rst) begin
      sw_q    <= 1'b0;
      rmode_q <= 2'h0;
      rmap_q  <= 1'b0;
      rswg_q  <= 1'b0;
      remp_q  <= 1'b0;
    end else if (reg_write_i) begin
      sw_q    <= 1'b1;
      rmode_q <= reg_mode_i;
      rmap_q  <= reg_map_i;
      rswg_q  <= reg_swing_i;
      remp_q  <= reg_emphasis_i;
    end
  end
  // Filter bit only: partner family stays pinned, hence partial override
  wire [1:0] mode   = sw_q ? {cfg_pin[1], (cfg_pin[1] ? cfg_pin[0] : rmode_q[0])} : cfg_pin;
  wire       map_ms = sw_q ? rmap_q : map_pin;
  wire       swing  = sw_q ? rswg_q : swg_pin;
  ////////////////////////////////////////////////////////////////////////////
  // Lane mapping: lane 3 carries MSB or LSB group
  // Inbound and outbound rotate opposite ways, so one map value round-trips
  function [W-1:0] remap;
    input [W-1:0] d;
    input         msb;
    input         rx_side;
    begin
      if (msb) begin
        remap = d;
      end else if (rx_side) begin
        remap = {d[W-LANE_W-1:0], d[W-1:W-LANE_W]};
      end else begin
        remap = {d[LANE_W-1:0], d[W-1:LANE_W]};
      end
    end
  endfunction
  // Link clock edge detect on synchronised copy
  reg  lclk_q;
  wire lrise = lclk & ~lclk_q;
  always @(posedge sys_clk_i) begin
    lclk_q <= lclk;
  end
  reg  [W-1:0] din_q;
  always @(posedge sys_clk_i) begin
    din_q <= parallel_data_in_i;
  end
  wire         f_ready;
  wire         f_valid;
  wire [W-1:0] f_data;
  // Words past the FIFO depth are dropped while the gate is shut
  wire         gate  = locked ? output_enable_in : (output_enable_in & oss);
  wire         drain = gate & ~bist;
  scpc_fifo #(.WIDTH(W), .DEPTH(DEPTH), .AW(FAW)) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .resetn_i    (resetn_i),
    .flush_i     (!pdn),
    .in_valid_i  (lrise & ~bist),
    .in_ready_o  (f_ready),
    .in_data_i   (remap(din_q, map_ms, 1'b1)),
    .out_valid_o (f_valid),
    .out_ready_i (drain),
    .out_data_o  (f_data)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  reg test_q;
  always @(posedge sys_clk_i) begin
    if (rst) begin
      parallel_data_out_o   <= {W{1'b0}};
      parallel_out_valid_o  <= 1'b0;
      parallel_out_enable_o <= 1'b0;
      in_ready_o            <= 1'b0;
      pll_run_o             <= 1'b0;
      serial_pos_o          <= 1'b1;
      serial_neg_o          <= 1'b1;
      filter_on_o           <= 1'b0;
      legacy_mode_o         <= 1'b0;
      partner_o             <= 2'h0;
      swing_high_o          <= 1'b0;
      emphasis_on_o         <= 1'b0;
      eq_high_o             <= 1'b0;
      spread_low_band_o     <= 1'b0;
      spread_range_o        <= 3'h0;
      test_mode_o           <= 1'b0;
      test_q                <= 1'b0;
      pass_o                <= 1'b1;
      lock_o                <= 1'b0;
      bus_address_o         <= {`SCPC_ADDR_W{1'b0}};
      sda_o                 <= 1'b0;
      sda_oe_o              <= 1'b0;
    end else begin
      if (drain && f_valid) begin
        parallel_data_out_o <= remap(f_data, map_ms, 1'b0);
      end
      parallel_out_valid_o  <= drain & f_valid;
      parallel_out_enable_o <= gate;
      in_ready_o            <= f_ready;
      pll_run_o             <= 1'b1;
      serial_pos_o          <= 1'b1;
      serial_neg_o          <= 1'b0;
      filter_on_o           <= (mode == `SCPC_MODE_MATE_FILT);
      legacy_mode_o         <= mode[1];
      partner_o             <= mode;
      swing_high_o          <= (swing == `SCPC_SWING_HIGH);
      // Floating pin reads high through the pullup, so low means resistor tied
      emphasis_on_o         <= ~emp_pin | (sw_q & remp_q);
      lock_o                <= locked;
      spread_low_band_o     <= (lfm == `SCPC_SPREAD_LOW_BAND);
      spread_range_o        <= ssc;
      test_mode_o           <= bist;
      test_q                <= bist;
      if (!bist) begin
        pass_o <= 1'b1;
      end else if (err) begin
        pass_o <= 1'b0;
      end
      // Strap tracked outside self-test, pin then serves as pass output
      if (!test_q && !bist) begin
        eq_high_o <= eq_pin;
      end
      bus_address_o <= addr_s2_q;
      sda_o         <= 1'b0;
      sda_oe_o      <= 1'b0;
    end
  end
endmodule
////////////////////////////////////////////////////////////////////////////
// Link word buffer; depth must be a power of two for the wrap-bit compare
module scpc_fifo #(
  parameter WIDTH = 28,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             sys_clk_i,
  input  wire             resetn_i,
  input  wire             flush_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0]      wr_q;
  reg [AW:0]      rd_q;
  wire [AW-1:0]   wr_a;
  wire [AW-1:0]   rd_a;
  wire            full;
  wire            empty;
  wire            push;
  wire            pop;
  assign wr_a        = wr_q[AW-1:0];
  assign rd_a        = rd_q[AW-1:0];
  assign full        = (wr_q[AW] != rd_q[AW]) && (wr_a == rd_a);
  assign empty       = (wr_q == rd_q);
  assign in_ready_o  = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o  = mem_q[rd_a];
  assign push        = in_valid_i & ~full;
  assign pop         = out_ready_i & ~empty;
  always @(posedge sys_clk_i) begin
    if (push) begin
      mem_q[wr_a] <= in_data_i;
    end
  end
  // Flush on power-down; otherwise only the reset port clears the pointers
  always @(posedge sys_clk_i) begin
    if (!resetn_i || flush_i) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/scpc_checker.sv ***
// Purpose: Port-level checks of the serdes pin control block
// Assumes: Pins settle at the outputs within 3 clocks, the 2 sync stages included
// Notes:   Pin-path checks are skipped once a register write took over
`timescale 1ns/1ps
`default_nettype none
module scpc_checker (
  input wire logic       sys_clk_i,
  input wire logic       resetn_i,
  input wire logic       power_down_n_i,
  input wire logic       reg_write_i,
  input wire logic       reg_swing_i,
  input wire logic       output_swing_select_i,
  input wire logic       pll_locked_i,
  input wire logic       output_enable_in_i,
  input wire logic       output_sleep_state_select_i,
  input wire logic       self_test_enable_i,
  input wire logic       test_error_i,
  input wire logic [1:0] mode_sel_i,
  input wire logic [1:0] partner_o,
  input wire logic       serial_pos_o,
  input wire logic       serial_neg_o,
  input wire logic       pll_run_o,
  input wire logic       parallel_out_enable_o,
  input wire logic       pass_o,
  input wire logic       test_mode_o,
  input wire logic       swing_high_o,
  input wire logic       lock_o,
  input wire logic       filter_on_o,
  input wire logic       legacy_mode_o,
  input wire logic       parallel_out_valid_o
);
  logic wr_q;
  // Tracks register override; power-down clears it like the device registers
  always @(posedge sys_clk_i) begin
    if (!resetn_i || !power_down_n_i) wr_q <= 1'b0;
    else if (reg_write_i) wr_q <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  a_reset_legs_high: assert property (disable iff (1'b0) !resetn_i |=> serial_pos_o && serial_neg_o && !pll_run_o)
    else $error("serial legs not parked in reset");
  a_reset_outputs_off: assert property (disable iff (1'b0) !resetn_i |=> !parallel_out_enable_o && pass_o)
    else $error("outputs not parked in reset");
  a_pd_legs_high: assert property ((!power_down_n_i)[*4] |-> serial_pos_o && serial_neg_o && !pll_run_o)
    else $error("serial legs not parked in power-down");
  a_swing_pin_high: assert property ((power_down_n_i && !wr_q && output_swing_select_i)[*8] |-> swing_high_o)
    else $error("swing does not follow pin");
  a_mode_decode: assert property ((power_down_n_i && !wr_q && $stable(mode_sel_i))[*8] |-> partner_o == mode_sel_i
    && filter_on_o == (mode_sel_i == 2'h1) && legacy_mode_o == mode_sel_i[1])
    else $error("mode decode wrong");
  a_reg_swing: assert property (power_down_n_i && reg_write_i |-> ##2 swing_high_o == $past(reg_swing_i, 2))
    else $error("register swing not applied");
  a_gate_locked: assert property ((power_down_n_i && pll_locked_i && output_enable_in_i)[*8]
    |-> lock_o && parallel_out_enable_o)
    else $error("locked gate wrong");
  a_gate_unlocked: assert property ((power_down_n_i && !pll_locked_i && !output_sleep_state_select_i)[*8]
    |-> !lock_o && !parallel_out_enable_o)
    else $error("unlocked gate wrong");
  a_pass_on_error: assert property ((self_test_enable_i && test_error_i)[*3] ##1 self_test_enable_i[*3]
    |-> test_mode_o && !pass_o)
    else $error("pass not cleared by error");
  a_pass_sticky: assert property (test_mode_o && !pass_o ##1 test_mode_o |-> !pass_o)
    else $error("pass recovered inside self-test");
  c_reg_write: cover property (reg_write_i);
  c_pass_low: cover property (test_mode_o && !pass_o);
  c_word_out: cover property (parallel_out_valid_o);
endmodule
`default_nettype wire

// *** verif/scpc_link_model.sv ***
// Purpose: Far-side parallel link source for the pin control block
// Assumes: One word per link clock of 160 ns
// Notes:   Clock stands low and data scrambles between frames
`timescale 1ns/1ps
`default_nettype none
module scpc_link_model (
  input  wire logic        run_i,
  output var  logic        clk_o,
  output var  logic [27:0] data_o
);
  logic [27:0] last;
  initial begin
    clk_o = 1'b0;
    last = 28'h0;
    data_o = 28'h0;
    forever begin
      // Released lines must not look like a stale word
      if (!run_i) begin
        data_o = ~last;
        wait (run_i);
      end
      last = 28'($urandom);
      data_o = last;
      #40 clk_o = 1'b1;
      #80 clk_o = 1'b0;
      #40;
    end
  end
endmodule
`default_nettype wire

// *** verif/scpc_top_test.sv ***
// Purpose: Self-checking bench of the serdes pin control block
// Assumes: 200 MHz clock, inputs driven on the falling edge
// Notes:   Lane map flips between FIFO fill and drain so both mappings show
`timescale 1ns/1ps
`default_nettype none
module scpc_top_test;
  logic sys_clk_i, resetn_i, power_down_n_i, lane_bit_map_select_i, output_swing_select_i, tx_emphasis_control_i;
  logic self_test_enable_i, rx_equalizer_strap_i, spread_low_band_mode_i, output_enable_in_i, reserved_input_i;
  logic output_sleep_state_select_i, pll_locked_i, test_error_i, reg_write_i, reg_map_i, reg_swing_i;
  logic reg_emphasis_i, scl_i, sda_i, sda_o, sda_oe_o, parallel_out_valid_o, parallel_out_enable_o, in_ready_o;
  logic pll_run_o, serial_pos_o, serial_neg_o, filter_on_o, legacy_mode_o, swing_high_o, emphasis_on_o, eq_high_o;
  logic spread_low_band_o, test_mode_o, pass_o, lock_o, run;
  logic [1:0] mode_sel_i, reg_mode_i, partner_o;
  logic [2:0] spread_range_select_i, bus_address_strap_i, spread_range_o, bus_address_o;
  logic [27:0] parallel_data_out_o, q[$];
  wire logic [27:0] parallel_data_in_i;
  wire logic parallel_clock_in_i;
  int bad_count, checks_done, cyc, i;
  scpc_top DUT (.*);
  scpc_link_model link (.run_i(run), .clk_o(parallel_clock_in_i), .data_o(parallel_data_in_i));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [27:0] ser_word(input logic [27:0] d, input logic m);
    return m ? d : {d[20:0], d[27:21]};
  endfunction
  function automatic logic [27:0] des_word(input logic [27:0] x, input logic m);
    return m ? x : {x[6:0], x[27:7]};
  endfunction
  task automatic chk(input string nm, input logic [27:0] e, input logic [27:0] s);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic settle();
    repeat (6) @(negedge sys_clk_i);
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // Ceiling well above the roughly 1100 cycles the sequence needs
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      wrap_up();
    end
  end
  always @(posedge parallel_clock_in_i) begin
    if (in_ready_o === 1'b1) q.push_back(ser_word(parallel_data_in_i, lane_bit_map_select_i));
  end
  always @(negedge sys_clk_i) if (parallel_out_valid_o === 1'b1) begin
    if (q.size() == 0) chk("extra word", 28'h0, 28'h1);
    else chk("word", des_word(q.pop_front(), lane_bit_map_select_i), parallel_data_out_o);
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hb27437ee));
    {resetn_i, power_down_n_i, mode_sel_i, lane_bit_map_select_i, output_swing_select_i, run} = '0;
    {self_test_enable_i, rx_equalizer_strap_i, spread_low_band_mode_i, spread_range_select_i} = '0;
    {output_enable_in_i, output_sleep_state_select_i, bus_address_strap_i, pll_locked_i, test_error_i} = '0;
    {reg_write_i, reg_mode_i, reg_map_i, reg_swing_i, reg_emphasis_i, reserved_input_i} = '0;
    {tx_emphasis_control_i, scl_i, sda_i} = 3'h7;
    repeat (5) @(negedge sys_clk_i);
    chk("legs", 28'h3, {pll_run_o, serial_pos_o, serial_neg_o});
    chk("enable", 28'h0, parallel_out_enable_o);
    resetn_i = 1'b1;
    power_down_n_i = 1'b1;
    settle();
    chk("legs run", 28'h6, {pll_run_o, serial_pos_o, serial_neg_o});
    for (i = 0; i < 16; i++) begin
      {output_swing_select_i, tx_emphasis_control_i, rx_equalizer_strap_i, spread_low_band_mode_i,
       spread_range_select_i, bus_address_strap_i} = 10'($urandom);
      mode_sel_i = 2'(i);
      settle();
      chk("partner", mode_sel_i, partner_o);
      chk("filter", mode_sel_i == 2'h1, filter_on_o);
      chk("legacy", mode_sel_i[1], legacy_mode_o);
      chk("swing", output_swing_select_i, swing_high_o);
      chk("emphasis", !tx_emphasis_control_i, emphasis_on_o);
      chk("eq", rx_equalizer_strap_i, eq_high_o);
      chk("band", spread_low_band_mode_i, spread_low_band_o);
      chk("range", spread_range_select_i, spread_range_o);
      chk("address", {bus_address_strap_i, 2'h0}, {bus_address_o, sda_oe_o, sda_o});
    end
    for (i = 0; i < 8; i++) begin
      {pll_locked_i, output_enable_in_i, output_sleep_state_select_i} = 3'(i);
      settle();
      chk("lock", pll_locked_i, lock_o);
      chk("gate", output_enable_in_i & (pll_locked_i | output_sleep_state_select_i), parallel_out_enable_o);
    end
    self_test_enable_i = 1'b1;
    settle();
    chk("test on", 28'h3, {test_mode_o, pass_o});
    test_error_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    test_error_i = 1'b0;
    settle();
    chk("pass held", 28'h2, {test_mode_o, pass_o});
    self_test_enable_i = 1'b0;
    settle();
    chk("test off", 28'h1, {test_mode_o, pass_o});
    {pll_locked_i, output_enable_in_i} = 2'h2;
    // Gate held off so the FIFO fills, then opened to drain it
    for (i = 0; i < 2; i++) begin
      lane_bit_map_select_i = 1'(i);
      run = 1'b1;
      repeat (10) @(negedge parallel_clock_in_i);
      run = 1'b0;
      lane_bit_map_select_i = !lane_bit_map_select_i;
      settle();
      chk("full", 28'h0, in_ready_o);
      output_enable_in_i = 1'b1;
      repeat (20) settle();
      chk("left", 28'h0, q.size());
      output_enable_in_i = 1'b0;
    end
    {mode_sel_i, output_swing_select_i, tx_emphasis_control_i} = 4'h1;
    {reg_mode_i, reg_swing_i, reg_emphasis_i, reg_write_i} = 5'h1f;
    @(negedge sys_clk_i);
    reg_write_i = 1'b0;
    settle();
    chk("override", 28'h7, {swing_high_o, emphasis_on_o, filter_on_o});
    power_down_n_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    chk("pd legs", 28'h6, {pll_run_o, serial_pos_o, serial_neg_o, parallel_out_enable_o});
    power_down_n_i = 1'b1;
    repeat (2) settle();
    chk("pins back", 28'h0, {swing_high_o, emphasis_on_o, filter_on_o});
    wrap_up();
  end
endmodule
bind scpc_top scpc_checker chk_i (.*);
`default_nettype wire
